//--- hw/pacc_defines.svh
// Constants for the sixteen-channel pulse accumulator
`ifndef PACC_DEFINES_SVH
`define PACC_DEFINES_SVH

// Channel organisation
`define PACC_NUM_GROUPS   2
`define PACC_PER_GROUP    8
`define PACC_NUM_CH       16
`define PACC_CNT_W        12
`define PACC_IDX_W        4

// Reset value of every counter
`define PACC_CNT_RST      12'h000

// Clock rate in Hz
`define PACC_CLK_HZ       40000000

// Filter cutoffs in Hz, printed figures
`define PACC_LF_CUT_HZ    200
`define PACC_HF_CUT_HZ    20000

// Input must hold a new level for half the cutoff period before it is
// accepted; longest stable time rounds down
`define PACC_LF_FILT_CYC  (`PACC_CLK_HZ / (2 * `PACC_LF_CUT_HZ))
`define PACC_HF_FILT_CYC  (`PACC_CLK_HZ / (2 * `PACC_HF_CUT_HZ))

// Width of the filter counter, large enough for the low-frequency count
`define PACC_FILT_W       17

`endif

//--- hw/pacc_pkg.sv
// Types shared by the pulse accumulator files
package pacc_pkg;

  // Variant selection
  typedef enum logic {
    PACC_VAR_LF,
    PACC_VAR_HF
  } pacc_var_t;

  // Read request from the host
  typedef struct packed {
    logic       rd;
    logic [3:0] ch;
  } pacc_req_t;

  // Read answer to the host
  typedef struct packed {
    logic        valid;
    logic [3:0]  ch;
    logic [11:0] count;
  } pacc_rsp_t;

endpackage

//--- hw/pacc_filter.sv
// Input filter and rising edge detector for one channel
`timescale 1ns/100ps
`include "pacc_defines.svh"

module pacc_filter
  import pacc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Settings
  input  wire logic [16:0] hold_cyc,
  // Field side
  input  wire logic        raw_in,
  // Result
  output logic             rise
);

  // ************************************************************
  // Filter state
  // ************************************************************
  logic                        lvl_q,  lvl_d;   // Accepted level
  logic [`PACC_FILT_W-1:0]     cnt_q,  cnt_d;   // Stability counter
  logic                        rise_q, rise_d;  // One-cycle edge pulse

  // Next-state: accept a level once it holds for hold_cyc cycles
  always_comb begin
    lvl_d  = lvl_q;
    cnt_d  = cnt_q;
    rise_d = 1'b0;
    if (raw_in == lvl_q) begin
      // Level agrees, restart the count
      cnt_d = '0;
    end else if (cnt_q >= hold_cyc - 17'd1) begin
      // Long enough: accept, flag an inactive-to-active edge
      lvl_d  = raw_in;
      cnt_d  = '0;
      rise_d = raw_in;
    end else begin
      // Short glitch still being timed, rejected if it ends now
      cnt_d = cnt_q + 17'd1;
    end
  end

  // Registers, frozen while clock enable is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q  <= 1'b0;
      cnt_q  <= '0;
      rise_q <= 1'b0;
    end else if (ce) begin
      lvl_q  <= lvl_d;
      cnt_q  <= cnt_d;
      rise_q <= rise_d;
    end
  end

  assign rise = rise_q & ce;

  // ************************************************************
  // Checks
  // ************************************************************
  glitch_reject_a : assert property (
    @(posedge clk) disable iff (!arst_n)
    (ce && raw_in != lvl_q && cnt_q < hold_cyc - 17'd1) |=> !rise_q)
    else $error("filter accepted a level too early");

endmodule

//--- hw/pacc_top.sv
// Sixteen-channel pulse accumulator with read-and-clear counters
`timescale 1ns/100ps
`include "pacc_defines.svh"

module pacc_top
  import pacc_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                      CLK,
  input  wire logic                      ARST_N,
  input  wire logic                      CE,
  // Variant strap, sampled every cycle
  input  wire pacc_var_t                 VARIANT,
  // Conditioned field inputs, group 0 in bits 7..0
  input  wire logic [`PACC_NUM_CH-1:0]   PULSE_IN,
  // Host read request
  input  wire pacc_req_t                 REQ,
  // Host read answer
  output pacc_rsp_t                      RSP
);

  // ************************************************************
  // Filter setting
  // ************************************************************
  logic [16:0] hold_cyc;  // Stability time for the chosen variant

  // VARIANT is live: a flip mid-pulse retimes the level being measured
  // Variant picks the filter cutoff
  always_comb begin
    if (VARIANT == PACC_VAR_LF) begin
      hold_cyc = 17'(`PACC_LF_FILT_CYC);
    end else begin
      hold_cyc = 17'(`PACC_HF_FILT_CYC);
    end
  end

  // ************************************************************
  // Per-channel filters
  // ************************************************************
  logic [`PACC_NUM_CH-1:0] rise;  // Filtered edge per channel

  // One filter per channel, two groups of eight
  genvar g;
  generate
    for (g = 0; g < `PACC_NUM_CH; g++) begin : g_ch
      pacc_filter u_filt (
        .clk      (CLK),
        .arst_n   (ARST_N),
        .ce       (CE),
        .hold_cyc (hold_cyc),
        .raw_in   (PULSE_IN[g]),
        .rise     (rise[g])
      );
    end
  endgenerate

  // ************************************************************
  // Counters and read path
  // ************************************************************
  // No overflow flag: a host that reads too slowly sees the count wrap
  logic [`PACC_CNT_W-1:0] cnt_q [`PACC_NUM_CH];  // Accumulators
  logic [`PACC_CNT_W-1:0] cnt_d [`PACC_NUM_CH];
  pacc_rsp_t              rsp_q, rsp_d;          // Registered answer

  // Clear and increment are folded into one next value: written as two
  // separate updates, a pulse landing in the read cycle would be lost
  // Counter step: a read reloads with the pulse of this cycle
  function automatic logic [`PACC_CNT_W-1:0] step(
    input logic [`PACC_CNT_W-1:0] cur,
    input logic                   clr,
    input logic                   inc
  );
    logic [`PACC_CNT_W-1:0] base;
    base = clr ? `PACC_CNT_RST : cur;
    step = base + {{(`PACC_CNT_W-1){1'b0}}, inc};
  endfunction

  // Next counts and answer
  always_comb begin
    rsp_d = '0;
    for (int i = 0; i < `PACC_NUM_CH; i++) begin
      // Own count per channel, pulse in the read cycle survives
      cnt_d[i] = step(cnt_q[i],
                      REQ.rd && (REQ.ch == `PACC_IDX_W'(i)), rise[i]);
    end
    if (REQ.rd) begin
      // Count since the previous read, as unsigned integer
      rsp_d.valid = 1'b1;
      rsp_d.ch    = REQ.ch;
      rsp_d.count = cnt_q[REQ.ch];
    end
  end

  // Registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < `PACC_NUM_CH; i++) begin
        cnt_q[i] <= `PACC_CNT_RST;
      end
      rsp_q <= '0;
    end else if (CE) begin
      cnt_q <= cnt_d;
      rsp_q <= rsp_d;
    end
  end

  // Answer straight from flip-flops, all zero after an enabled edge without a read
  assign RSP = rsp_q;

  // ************************************************************
  // Checks
  // ************************************************************
  // Every check sleeps through reset; CE low freezes the expected
  // values together with the state they are compared against

  // Read without a pulse leaves the channel at zero
  clear_on_read_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && REQ.rd && !rise[REQ.ch]) |=> cnt_q[$past(REQ.ch)] == 12'h000)
    else $error("counter not cleared by read");

  // Read in the cycle of a pulse keeps that pulse
  keep_pulse_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && REQ.rd && rise[REQ.ch]) |=> cnt_q[$past(REQ.ch)] == 12'h001)
    else $error("pulse lost during read");

  // Answer carries the count before the clear
  answer_value_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && REQ.rd) |=> RSP.valid && RSP.count == $past(cnt_q[REQ.ch]))
    else $error("answer does not match count");

  // Channel 0 steps once per filtered edge
  count_step_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && !REQ.rd && rise[0]) |=> cnt_q[0] == 12'($past(cnt_q[0]) + 1))
    else $error("counter did not step");

  // Channel 0 holds when nothing happens
  hold_count_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && !REQ.rd && !rise[0]) |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("counter moved without a pulse");

  // Channel 15 count and the answer hold while CE is low
  freeze_ce_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    !CE |=> cnt_q[15] == $past(cnt_q[15]) && RSP == $past(RSP))
    else $error("state moved while disabled");

  // No answer appears without a request
  idle_answer_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && !REQ.rd) |=> !RSP.valid)
    else $error("answer without request");

  // Reading another channel leaves channel 1 alone
  other_ch_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && REQ.rd && REQ.ch != 4'h1 && !rise[1])
      |=> cnt_q[1] == $past(cnt_q[1]))
    else $error("read disturbed another channel");

  // Group 0 reads leave the first channel of group 1 alone
  group_split_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && REQ.rd && !REQ.ch[3] && !rise[8])
      |=> cnt_q[8] == $past(cnt_q[8]))
    else $error("group 0 read disturbed group 1");

  // Channel 8 steps like channel 0
  count_step_hi_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && !REQ.rd && rise[8]) |=> cnt_q[8] == 12'($past(cnt_q[8]) + 1))
    else $error("group 1 counter did not step");

  // Channel 0 counter frozen while CE is low
  freeze_count_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    !CE |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("counter moved while disabled");

  // ************************************************************
  // Read handshake steps
  // ************************************************************
  // Step one: a read taken on an enabled edge
  sequence rd_taken_s;
    CE && REQ.rd;
  endsequence

  // Step two: the answer names the channel asked for
  sequence rd_echo_s;
    RSP.valid && RSP.ch == $past(REQ.ch);
  endsequence

  // A lone read: taken, then an enabled edge with no new request
  sequence rd_walk_s;
    rd_taken_s ##1 (CE && !REQ.rd);
  endsequence

  // Answer echoes the requested channel
  answer_echo_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    rd_taken_s |=> rd_echo_s)
    else $error("answer names the wrong channel");

  // Answer stands one cycle, then the whole word returns to zero
  answer_once_a : assert property (
    @(posedge CLK) disable iff (!ARST_N)
    rd_walk_s |=> RSP == '0)
    else $error("answer stood longer than one cycle");

endmodule

//--- sim/pacc_host_model.sv
// Host model issuing channel reads on the request port
`timescale 1ns/100ps

module pacc_host_model
  import pacc_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Read request
  output pacc_req_t req
);
  // Idle at start
  initial req = '0;

  // Back-to-back reads, index stepping by st
  task automatic burst(input logic [3:0] c0, input int n,
                       input logic [3:0] st);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1 req.rd = 1'b1;
      req.ch = c0 + st * i[3:0];
    end
    @(posedge clk);
    #1 req.rd = 1'b0;
    // Index no longer qualified: show no stale value
    req.ch = ~req.ch;
  endtask
endmodule

//--- sim/tb_pacc_top.sv
// Self-checking bench for the pulse accumulator
`timescale 1ns/100ps
`include "pacc_defines.svh"

module tb_pacc_top;
  import pacc_pkg::*;
  // ****************
  // Signals and model
  // ****************
  localparam int N = `PACC_HF_FILT_CYC; // Filter hold
  logic        clk = 0;
  logic        arst_n = 0;
  logic        ce = 0;
  pacc_var_t   vsel = PACC_VAR_HF;
  logic [15:0] pin = '0;
  pacc_req_t   req;
  pacc_rsp_t   rsp;
  logic [16:0] expq[$];   // Expected answers, msb set when checked
  logic [16:0] e;         // Oldest note
  logic [11:0] cnt[16];   // Model counts
  logic [31:0] seed = 32'h0000_c9de;
  logic [31:0] r;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          tot = 0;

  pacc_top dut_u (.CLK(clk), .ARST_N(arst_n), .CE(ce), .VARIANT(vsel),
    .PULSE_IN(pin), .REQ(req), .RSP(rsp));
  pacc_host_model host_u (.clk(clk), .req(req));

  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string nm, logic [16:0] seen, logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Monitor: answers against the oldest note, zero when idle
  always @(negedge clk) begin
    if (rsp.valid === 1'b1) begin
      e = expq.size() ? expq.pop_front() : 17'h1_ffff;
      if (e[16]) chk("rsp", rsp, e);
      else begin
        tot += rsp.count;
        chk("ch", {13'h0000, rsp.ch}, {13'h0000, e[15:12]});
      end
    end else chk("idle", rsp, 17'h0_0000);
  end

  // Pulse on mask m held len cycles, then low long enough
  task automatic pulse(logic [15:0] m, int len);
    @(posedge clk);
    #1 pin = m;
    repeat (len) @(posedge clk);
    #1 pin = '0;
    repeat (N + 5) @(posedge clk);
    for (int i = 0; i < 16; i++)
      if (m[i] && len >= N && vsel == PACC_VAR_HF) cnt[i]++;
  endtask

  // Read all sixteen channels back to back, well before overflow
  task automatic read_all();
    for (int i = 0; i < 16; i++) begin
      expq.push_back({1'b1, i[3:0], cnt[i]});
      cnt[i] = '0;
    end
    host_u.burst(4'h0, 16, 4'h1);
    repeat (2) @(posedge clk);
  endtask

  initial begin
    for (int i = 0; i < 16; i++) cnt[i] = '0;
    repeat (10) @(posedge clk);
    #1 arst_n = 1;
    ce = 1;
    read_all();
    for (int k = 0; k < 5; k++) begin
      r = xs();
      pulse(r[15:0], N + 5);
    end
    read_all();
    pulse(16'hffff, N / 2); // Short pulse dropped
    #1 vsel = PACC_VAR_LF;
    pulse(16'h00ff, N + 5); // Slow filter rejects it
    #1 vsel = PACC_VAR_HF;
    read_all();
    // Disabled clock: request ignored, answer stays idle
    #1 ce = 0;
    host_u.burst(4'h5, 1, 4'h0);
    ce = 1;
    // Continuous reads of one channel while it pulses
    for (int i = 0; i < 2 * N + 10; i++) expq.push_back(17'h0_3000);
    fork
      pulse(16'h0008, N + 5);
      host_u.burst(4'h3, 2 * N + 10, 4'h0);
    join
    repeat (2) @(posedge clk);
    chk("sum", tot[16:0], 17'h0_0001);
    cnt[3] = '0;
    // Answer frozen while CE is low; the read on the frozen edge is lost
    pulse(16'h0101, N + 5);
    expq.push_back({1'b1, 4'h8, cnt[8]});
    expq.push_back({1'b1, 4'h8, cnt[8]});
    cnt[8] = '0;
    fork
      host_u.burst(4'h8, 2, 4'h0);
      begin
        repeat (2) @(posedge clk);
        #1 ce = 0;
        @(posedge clk);
        #1 ce = 1;
      end
    join
    // Counts lost on a mid-run reset
    @(posedge clk);
    #1 arst_n = 0;
    for (int i = 0; i < 16; i++) cnt[i] = '0;
    repeat (3) @(posedge clk);
    #1 arst_n = 1;
    read_all();
    chk("pending", 17'(expq.size()), 17'h0_0000);
    report_and_stop();
  end
endmodule
